// ==== design/ufc_fifo_control.sv ====
// UART FIFO control: tx/rx FIFOs, flushes, trigger level, identification, APB slave
//
// Operation
// - fifo_control is write-only; reads at its address return interrupt identification.
// - Trigger field bits 7:6 selects 1, 8, 16 or 32 bytes.
// - Tx flush bit 2 sets tx count to zero.
// - Tx flush sets tx data request flag; reports tx request if enabled.
// - Tx flush leaves the character being shifted out alone.
// - Tx flush bit self-clears; writing zero does nothing.
// - Rx flush bit 1 empties rx FIFO and clears data ready flag.
// - Rx flush clears per-entry error bits and FIFO error flag.
// - Rx flush keeps overrun, parity, framing and break flags set.
// - Rx flush leaves the receiver shift register alone.
// - Rx flush clears a pending received-data-available indication.
// - Rx flush bit self-clears; writing zero does nothing.
// - Bit 0 enables both FIFOs when one, disables both when zero.
// - Writing zero to enable bit discards both FIFOs.
// - Mode status reads 11 in FIFO mode, 00 otherwise.
// - Time-out indication cleared by reading rx FIFO or rx flush.
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo_control #(
  parameter int depth = 32,
  parameter int cnt_w = 6,
  parameter int timeout_cycles = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ufc_pkg::ufc_rx_in_t rx_in,
  output logic rx_ready,
  output var ufc_pkg::ufc_tx_out_t tx_out,
  input wire logic tx_taken,
  input wire logic rx_overrun,
  output logic irq
);
  import ufc_pkg::*;

  // Register map, one word each, byte addresses:
  //   0x00 data: a read pops the rx FIFO, a write pushes the tx FIFO
  //   0x04 interrupt_enable_reg: rx data, tx request, line status
  //   0x08 fifo_control on write, interrupt_identification on read
  //   0x14 line_status_reg: a read clears overrun, parity, framing and break
  //   0x20 interrupt status, sticky, cleared by reading it
  //   0x24 interrupt mask, same layout as the status
  //   0x28 and 0x2c: live tx and rx entry counts
  // Unmapped addresses read zero and ignore writes; the bus never signals an error.

  // All block state in one record
  typedef struct packed {
    ufc_rx_entry_t [depth-1:0] rx_mem;
    logic [depth-1:0][7:0] tx_mem;
    logic [cnt_w-1:0] rx_cnt;
    logic [cnt_w-1:0] tx_cnt;
    logic [cnt_w-2:0] rx_rd;
    logic [cnt_w-2:0] tx_rd;
    logic fifo_en;
    logic [1:0] trig;
    logic [2:0] interrupt_enable_reg;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic tx_data_request_flag;
    logic tout;
    logic treq_pend;
    logic [15:0] idle_cnt;
    logic [ufc_ev_n-1:0] ists;
    logic [ufc_ev_n-1:0] imask;
    logic [31:0] rdata;
    logic ack;
  } ufc_state_t;

  ufc_state_t r;
  ufc_state_t next_r;

  logic acc;
  logic wr;
  logic rd;
  logic [cnt_w-1:0] cap;
  logic [5:0] trig_lvl;
  logic rx_push;
  logic tx_push;
  logic tx_pop;
  logic rx_pop;
  logic rx_flush;
  logic tx_flush;
  logic rda;
  logic rls;
  logic err_in_fifo;
  logic [3:0] iid;
  logic [cnt_w-2:0] rx_wr;
  logic [cnt_w-2:0] tx_wr;
  logic [ufc_ev_n-1:0] ev;
  logic [depth-1:0] err_vec;

  // One wait state: the first access cycle registers read data and read side effects;
  // pready follows one cycle later, so prdata already stands at the edge where the
  // master samples it, and writes land at that same edge. A frozen clock holds pready
  // low, so no request is answered while nothing can be taken.
  assign acc = psel && penable && !r.ack;
  assign pready = psel && penable && r.ack && clk_en;
  assign wr = pready && pwrite;
  assign rd = acc && !pwrite;
  assign pslverr = 1'b0;
  assign prdata = r.rdata;
  assign irq = |(r.ists & r.imask);

  // Non-FIFO mode behaves as a one-entry holding register
  assign cap = r.fifo_en ? cnt_w'(depth) : cnt_w'(1);

  // Trigger threshold decode
  always_comb begin
    case (r.trig)
      2'h0: trig_lvl = ufc_trig_1;
      2'h1: trig_lvl = ufc_trig_8;
      2'h2: trig_lvl = ufc_trig_16;
      default: trig_lvl = ufc_trig_32;
    endcase
  end

  // Flush strobes act only in the write cycle, so the bits never stay set
  assign rx_flush = wr && paddr == ufc_addr_fcr &&
    (pwdata[ufc_fcr_rx_flush_bit] || !pwdata[ufc_fcr_enable_bit]);
  assign tx_flush = wr && paddr == ufc_addr_fcr &&
    (pwdata[ufc_fcr_tx_flush_bit] || !pwdata[ufc_fcr_enable_bit]);

  assign rx_pop = rd && paddr == ufc_addr_data && r.rx_cnt != '0;
  assign tx_push = wr && paddr == ufc_addr_data && r.tx_cnt < cap;
  assign rx_ready = !rx_flush && r.rx_cnt < cap;
  // Shift register outside keeps running across a flush
  assign rx_push = rx_in.valid && rx_ready;
  // Head of the tx FIFO; one assignment keeps a single driver on the record
  assign tx_out = '{valid: r.tx_cnt != '0, data: r.tx_mem[r.tx_rd]};
  assign tx_pop = tx_taken && tx_out.valid && !tx_flush;
  assign rx_wr = (cnt_w - 1)'(r.rx_rd + r.rx_cnt[cnt_w-2:0]);
  assign tx_wr = (cnt_w - 1)'(r.tx_rd + r.tx_cnt[cnt_w-2:0]);

  // Error summary over live entries
  genvar gi;
  generate
    for (gi = 0; gi < depth; gi++) begin : g_err
      logic [cnt_w-2:0] ofs;
      ufc_rx_entry_t e;
      assign ofs = (cnt_w - 1)'(gi) - r.rx_rd;
      assign e = r.rx_mem[gi];
      assign err_vec[gi] = (cnt_w'(ofs) < r.rx_cnt) && (e.pe || e.fe || e.bi);
    end
  endgenerate
  assign err_in_fifo = |err_vec && r.fifo_en;

  // Interrupt sources and identification priority
  // Order: line status, then data available, then character time-out, then tx request.
  // Only the highest pending source is shown; reading the identification clears a
  // shown tx request and nothing else, so lower sources reappear once higher ones go.
  assign rls = r.interrupt_enable_reg[ufc_ier_rls_bit] && (r.oe || r.pe || r.fe || r.bi || err_in_fifo);
  assign rda = r.interrupt_enable_reg[ufc_ier_rx_bit] && (r.fifo_en ? r.rx_cnt >= cnt_w'(trig_lvl) : r.rx_cnt != '0);
  always_comb begin
    if (rls) begin
      iid = ufc_iid_rls;
    end else if (rda) begin
      iid = ufc_iid_rda;
    end else if (r.tout && r.interrupt_enable_reg[ufc_ier_rx_bit]) begin
      iid = ufc_iid_tout;
    end else if (r.treq_pend && r.interrupt_enable_reg[ufc_ier_tx_bit]) begin
      iid = ufc_iid_treq;
    end else begin
      iid = ufc_iid_none;
    end
  end

  assign ev = {r.tout, rls, r.treq_pend && r.interrupt_enable_reg[ufc_ier_tx_bit], rda};

  // Next state
  always_comb begin
    next_r = r;
    next_r.ack = acc;
    // Receive side
    if (rx_flush) begin
      next_r.rx_cnt = '0;
      next_r.rx_rd = '0;
      next_r.rx_mem = '0;
      next_r.tout = 1'b0;
    end else begin
      if (rx_push) begin
        next_r.rx_mem[rx_wr] = rx_in.entry;
      end
      if (rx_pop) begin
        next_r.rx_rd = (cnt_w - 1)'(r.rx_rd + 1'b1);
        next_r.tout = 1'b0;
      end
      next_r.rx_cnt = cnt_w'(r.rx_cnt + cnt_w'(rx_push) - cnt_w'(rx_pop));
    end
    // Character time-out: data waiting with no activity
    if (rx_push || rx_pop || rx_flush || r.rx_cnt == '0 || !r.fifo_en) begin
      next_r.idle_cnt = '0;
    end else if (r.idle_cnt == 16'(timeout_cycles)) begin
      next_r.tout = 1'b1;
    end else begin
      next_r.idle_cnt = 16'(r.idle_cnt + 1'b1);
    end
    // Line status flags set by receiver; flush does not touch them
    if (rx_overrun) begin
      next_r.oe = 1'b1;
    end
    if (rx_push && rx_in.entry.pe) begin
      next_r.pe = 1'b1;
    end
    if (rx_push && rx_in.entry.fe) begin
      next_r.fe = 1'b1;
    end
    if (rx_push && rx_in.entry.bi) begin
      next_r.bi = 1'b1;
    end
    // Transmit side
    if (tx_flush) begin
      next_r.tx_cnt = '0;
      next_r.tx_rd = '0;
      next_r.tx_data_request_flag = 1'b1;
      next_r.treq_pend = 1'b1;
    end else begin
      if (tx_push) begin
        next_r.tx_mem[tx_wr] = pwdata[7:0];
        next_r.treq_pend = 1'b0;
      end
      if (tx_pop) begin
        next_r.tx_rd = (cnt_w - 1)'(r.tx_rd + 1'b1);
      end
      next_r.tx_cnt = cnt_w'(r.tx_cnt + cnt_w'(tx_push) - cnt_w'(tx_pop));
      // Request data when half or less full
      next_r.tx_data_request_flag = (next_r.tx_cnt <= (cap >> 1));
      if (next_r.tx_data_request_flag && !r.tx_data_request_flag) next_r.treq_pend = 1'b1;
    end
    // Register writes; reserved bits are dropped
    if (wr) begin
      if (paddr == ufc_addr_fcr) begin
        next_r.fifo_en = pwdata[ufc_fcr_enable_bit];
        next_r.trig = pwdata[ufc_fcr_trig_lo+1:ufc_fcr_trig_lo];
      end else if (paddr == ufc_addr_ier) begin
        next_r.interrupt_enable_reg = pwdata[2:0];
      end else if (paddr == ufc_addr_irq_mask) begin
        next_r.imask = pwdata[ufc_ev_n-1:0];
      end
    end
    // Read data and read side effects
    next_r.rdata = '0;
    if (rd) begin
      if (paddr == ufc_addr_data) begin
        next_r.rdata[7:0] = r.rx_mem[r.rx_rd].data;
      end else if (paddr == ufc_addr_ier) begin
        next_r.rdata[2:0] = r.interrupt_enable_reg;
      end else if (paddr == ufc_addr_fcr) begin
        // Identification read; mode status bits 7:6
        next_r.rdata[7:6] = r.fifo_en ? ufc_mode_fifo : ufc_mode_plain;
        next_r.rdata[3:0] = iid;
        // A request raised in this very cycle is newer than the one being read out
        if (iid == ufc_iid_treq && !(next_r.tx_data_request_flag && !r.tx_data_request_flag)) begin
          next_r.treq_pend = 1'b0;
        end
      end else if (paddr == ufc_addr_lsr) begin
        next_r.rdata[ufc_lsr_dr_bit] = r.rx_cnt != '0;
        next_r.rdata[ufc_lsr_oe_bit] = r.oe;
        next_r.rdata[ufc_lsr_pe_bit] = r.pe;
        next_r.rdata[ufc_lsr_fe_bit] = r.fe;
        next_r.rdata[ufc_lsr_bi_bit] = r.bi;
        next_r.rdata[ufc_lsr_tx_data_request_flag_bit] = r.tx_data_request_flag;
        next_r.rdata[ufc_lsr_rx_fifo_error_flag_bit] = err_in_fifo;
        // Read clears the flags, but an error arriving in the same cycle survives
        next_r.oe = rx_overrun;
        next_r.pe = rx_push && rx_in.entry.pe;
        next_r.fe = rx_push && rx_in.entry.fe;
        next_r.bi = rx_push && rx_in.entry.bi;
      end else if (paddr == ufc_addr_irq_status) begin
        next_r.rdata[ufc_ev_n-1:0] = r.ists;
      end else if (paddr == ufc_addr_irq_mask) begin
        next_r.rdata[ufc_ev_n-1:0] = r.imask;
      end else if (paddr == ufc_addr_tx_level) begin
        next_r.rdata[cnt_w-1:0] = r.tx_cnt;
      end else if (paddr == ufc_addr_rx_level) begin
        next_r.rdata[cnt_w-1:0] = r.rx_cnt;
      end
    end
    // Sticky status: read clears, but a new event wins
    if (rd && paddr == ufc_addr_irq_status) begin
      next_r.ists = ev;
    end else begin
      next_r.ists = r.ists | ev;
    end
    // A flush withdraws the pending data-available indication
    if (rx_flush) begin
      next_r.ists[ufc_ev_rda] = 1'b0;
      next_r.ists[ufc_ev_tout] = 1'b0;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.tx_data_request_flag <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ==== design/ufc_pkg.sv ====
// Package for the UART FIFO control block: offsets, fields, types
package ufc_pkg;
  // Register byte addresses (APB, one word each)
  localparam logic [7:0] ufc_addr_data = 8'h00;  // Read pops rx FIFO, write pushes tx FIFO
  localparam logic [7:0] ufc_addr_ier = 8'h04;   // interrupt_enable_reg
  localparam logic [7:0] ufc_addr_fcr = 8'h08;   // fifo_control (write) / interrupt_identification (read)
  localparam logic [7:0] ufc_addr_lsr = 8'h14;   // line_status_reg
  localparam logic [7:0] ufc_addr_irq_status = 8'h20;
  localparam logic [7:0] ufc_addr_irq_mask = 8'h24;
  localparam logic [7:0] ufc_addr_tx_level = 8'h28;
  localparam logic [7:0] ufc_addr_rx_level = 8'h2c;
  // fifo_control fields
  localparam int ufc_fcr_enable_bit = 0;
  localparam int ufc_fcr_rx_flush_bit = 1;
  localparam int ufc_fcr_tx_flush_bit = 2;
  localparam int ufc_fcr_trig_lo = 6;
  // interrupt_enable_reg fields
  localparam int ufc_ier_rx_bit = 0;
  localparam int ufc_ier_tx_bit = 1;
  localparam int ufc_ier_rls_bit = 2;
  // line_status_reg fields
  localparam int ufc_lsr_dr_bit = 0;
  localparam int ufc_lsr_oe_bit = 1;
  localparam int ufc_lsr_pe_bit = 2;
  localparam int ufc_lsr_fe_bit = 3;
  localparam int ufc_lsr_bi_bit = 4;
  localparam int ufc_lsr_tx_data_request_flag_bit = 5;
  localparam int ufc_lsr_rx_fifo_error_flag_bit = 7;
  // Trigger thresholds for codes 00..11
  localparam logic [5:0] ufc_trig_1 = 6'h01;
  localparam logic [5:0] ufc_trig_8 = 6'h08;
  localparam logic [5:0] ufc_trig_16 = 6'h10;
  localparam logic [5:0] ufc_trig_32 = 6'h20;
  // Identification codes (bits 3:0)
  localparam logic [3:0] ufc_iid_none = 4'h1;
  localparam logic [3:0] ufc_iid_rls = 4'h6;
  localparam logic [3:0] ufc_iid_rda = 4'h4;
  localparam logic [3:0] ufc_iid_tout = 4'hc;
  localparam logic [3:0] ufc_iid_treq = 4'h2;
  localparam logic [1:0] ufc_mode_fifo = 2'h3;
  localparam logic [1:0] ufc_mode_plain = 2'h0;
  // Interrupt status bits
  localparam int ufc_ev_rda = 0;
  localparam int ufc_ev_treq = 1;
  localparam int ufc_ev_rls = 2;
  localparam int ufc_ev_tout = 3;
  localparam int ufc_ev_n = 4;
  localparam logic [2:0] ufc_ier_reset = 3'h0;
  localparam logic [1:0] ufc_trig_reset = 2'h0;

  // Received entry: data plus per-entry error bits
  typedef struct packed {
    logic [7:0] data;
    logic pe;
    logic fe;
    logic bi;
  } ufc_rx_entry_t;

  // Serial-side handshakes
  typedef struct packed {
    logic valid;
    ufc_rx_entry_t entry;
  } ufc_rx_in_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufc_tx_out_t;
endpackage

// ==== tb/tb.sv ====
// Self-checking bench for the UART FIFO control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ufc_pkg::*;
  typedef struct packed {
    logic [1:0] code;
    logic [5:0] n;
  } ufc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, rx_ready, tx_taken, irq, busy;
  logic rx_overrun = 1'b0, send_go = 1'b0, err_en = 1'b0, tx_hold = 1'b0;
  logic [6:0] send_count = 7'h00;
  ufc_rx_in_t rx_in;
  ufc_tx_out_t tx_out;
  int n_fail = 0, samples_checked = 0, k;
  ufc_row_t rows [4] = '{'{2'h0, ufc_trig_1}, '{2'h1, ufc_trig_8}, '{2'h2, ufc_trig_16}, '{2'h3, ufc_trig_32}};
  ufc_fifo_control #(.depth(32)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .rx_ready(rx_ready), .tx_out(tx_out), .tx_taken(tx_taken),
    .rx_overrun(rx_overrun), .irq(irq));
  ufc_far_model far (.pclk(pclk), .presetn(presetn), .rx_ready(rx_ready), .tx_out(tx_out),
    .send_count(send_count), .send_go(send_go), .err_en(err_en), .tx_hold(tx_hold), .rx_in(rx_in),
    .tx_taken(tx_taken), .busy(busy));
  always #2.5 pclk = ~pclk;
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // Setup, then access until pready; read data is taken at the pready edge itself
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 50);
    if (pready !== 1'b1) begin n_fail++; print_verdict(); end
    rd_q = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd_q & m);
  endtask
  task automatic send(input logic [6:0] n);
    int j;
    send_count <= n;
    send_go <= 1'b1;
    @(posedge pclk);
    send_go <= 1'b0;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (busy && j < 100);
    if (busy) begin n_fail++; print_verdict(); end
  endtask
  function automatic logic [31:0] iid(input logic [1:0] m, input logic [3:0] c);
    return {24'h0, m, 2'h0, c};
  endfunction
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_plain, ufc_iid_none));
    apb(1'b1, ufc_addr_ier, 32'h1);
    apb(1'b1, ufc_addr_irq_mask, 32'h1);
    // One row per trigger code; reserved bits 5:3 are written high, bits 31:8 with a5a5a5
    foreach (rows[i]) begin
      apb(1'b1, ufc_addr_fcr, {24'ha5a5a5, rows[i].code, 6'h39});
      send({1'b0, rows[i].n} - 7'h01);
      rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_fifo, ufc_iid_none));
      send(7'h01);
      rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_fifo, ufc_iid_rda));
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, ufc_addr_irq_mask, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, ufc_addr_irq_mask, 32'h1);
      rchk("rx level", ufc_addr_rx_level, 32'hff, {26'h0, rows[i].n});
      apb(1'b1, ufc_addr_fcr, {24'h0, rows[i].code, 6'h03});
      rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_fifo, ufc_iid_none));
      rchk("rx level", ufc_addr_rx_level, 32'hff, 32'h0);
      rchk("status", ufc_addr_irq_status, 32'h1, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Errored byte, overrun and time-out, then an rx flush
    apb(1'b1, ufc_addr_fcr, 32'h41);
    err_en <= 1'b1;
    send(7'h01);
    err_en <= 1'b0;
    rx_overrun <= 1'b1;
    @(posedge pclk);
    rx_overrun <= 1'b0;
    k = 0;
    do begin
      apb(1'b0, ufc_addr_fcr, 32'h0);
      k++;
    end while (rd_q[3:0] !== ufc_iid_tout && k < 40);
    chk("timeout", iid(ufc_mode_fifo, ufc_iid_tout), rd_q & 32'hff);
    apb(1'b1, ufc_addr_fcr, 32'h43);
    rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_fifo, ufc_iid_none));
    rchk("lsr", ufc_addr_lsr, 32'h9f, 32'h6);
    // Stalled transmitter, more than half full, then a tx flush
    tx_hold <= 1'b1;
    apb(1'b1, ufc_addr_ier, 32'h2);
    for (k = 0; k < 20; k++) apb(1'b1, ufc_addr_data, 32'(k));
    rchk("tx_data_request_flag", ufc_addr_lsr, 32'h20, 32'h0);
    apb(1'b1, ufc_addr_fcr, 32'h05);
    rchk("tx level", ufc_addr_tx_level, 32'hff, 32'h0);
    rchk("tx_data_request_flag", ufc_addr_lsr, 32'h20, 32'h20);
    rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_fifo, ufc_iid_treq));
    apb(1'b1, ufc_addr_data, 32'haa);
    apb(1'b1, ufc_addr_fcr, 32'h01);
    rchk("tx level", ufc_addr_tx_level, 32'hff, 32'h1);
    // Disable with both FIFOs holding data, then one-entry mode
    send(7'h02);
    apb(1'b1, ufc_addr_fcr, 32'h0);
    rchk("tx level", ufc_addr_tx_level, 32'hff, 32'h0);
    rchk("rx level", ufc_addr_rx_level, 32'hff, 32'h0);
    rchk("mode", ufc_addr_fcr, 32'hc0, 32'h0);
    apb(1'b1, ufc_addr_data, 32'h11);
    apb(1'b1, ufc_addr_data, 32'h22);
    rchk("tx level", ufc_addr_tx_level, 32'hff, 32'h1);
    apb(1'b1, 8'h3c, 32'hffffffff);
    rchk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    chk("tx head", 32'h111, {23'h0, tx_out});
    tx_hold <= 1'b0;
    repeat (4) @(posedge pclk);
    rchk("tx level", ufc_addr_tx_level, 32'hff, 32'h0);
    // Reset in mid-run: everything returns to its idle state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rchk("iid", ufc_addr_fcr, 32'hff, iid(ufc_mode_plain, ufc_iid_none));
    rchk("tx_data_request_flag", ufc_addr_lsr, 32'h21, 32'h20);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/ufc_checker_assertions.sv ====
// Port-level assertions for the UART FIFO control block
`timescale 1ns/1ps
`default_nettype none
module ufc_checker
  import ufc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire ufc_pkg::ufc_rx_in_t rx_in,
  input wire logic rx_ready,
  input wire ufc_pkg::ufc_tx_out_t tx_out
);
  logic wr, rd, fw, en_q, rx_e, tx_e;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accesses completed at the pins; read data stands in the pready cycle
  assign wr = psel && penable && pready && clk_en && pwrite;
  assign rd = psel && penable && pready && clk_en && !pwrite;
  assign fw = wr && paddr == ufc_addr_fcr;
  // Shadow state; pushes win over flushes so emptiness is claimed only when certain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      rx_e <= 1'b1;
      tx_e <= 1'b1;
    end else begin
      if (fw) en_q <= pwdata[0];
      if (clk_en && rx_in.valid && rx_ready) rx_e <= 1'b0;
      else if (fw && (pwdata[1] || !pwdata[0])) rx_e <= 1'b1;
      if (wr && paddr == ufc_addr_data) tx_e <= 1'b0;
      else if (fw && (pwdata[2] || !pwdata[0])) tx_e <= 1'b1;
    end
  end
  property p_mode; rd && paddr == ufc_addr_fcr |-> prdata[7:6] == {2{en_q}}; endproperty
  a_mode: assert property (p_mode) else $error("mode status");
  property p_off; fw && !pwdata[0] |=> !tx_out.valid [*2]; endproperty
  a_off: assert property (p_off) else $error("disable kept tx");
  property p_txf; fw && pwdata[2] |=> !tx_out.valid; endproperty
  a_txf: assert property (p_txf) else $error("tx flush kept data");
  property p_push; wr && paddr == ufc_addr_data && tx_e |=> tx_out.valid; endproperty
  a_push: assert property (p_push) else $error("push lost");
  property p_txl; rd && paddr == ufc_addr_tx_level && tx_e |-> prdata == 32'h0; endproperty
  a_txl: assert property (p_txl) else $error("tx level");
  property p_tx_data_request_flag; rd && paddr == ufc_addr_lsr && tx_e |-> prdata[ufc_lsr_tx_data_request_flag_bit]; endproperty
  a_tx_data_request_flag: assert property (p_tx_data_request_flag) else $error("tx request flag");
  property p_rxl; rd && paddr == ufc_addr_rx_level && rx_e |-> prdata == 32'h0; endproperty
  a_rxl: assert property (p_rxl) else $error("rx level");
  property p_dr; rd && paddr == ufc_addr_lsr && rx_e |-> !prdata[ufc_lsr_dr_bit] && !prdata[7]; endproperty
  a_dr: assert property (p_dr) else $error("ready or error flag");
  // Line status may still be shown over an empty FIFO, so only the data sources are excluded
  property p_iid;
    rd && paddr == ufc_addr_fcr && rx_e |-> prdata[3:0] != ufc_iid_rda && prdata[3:0] != ufc_iid_tout;
  endproperty
  a_iid: assert property (p_iid) else $error("rx indication");
endmodule
bind ufc_fifo_control ufc_checker u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .rx_in(rx_in),
  .rx_ready(rx_ready), .tx_out(tx_out));
`default_nettype wire

// ==== tb/ufc_far_model.sv ====
// Far-side model: receive shift logic and transmit shifter
`timescale 1ns/1ps
`default_nettype none
module ufc_far_model
  import ufc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_ready,
  input wire ufc_pkg::ufc_tx_out_t tx_out,
  input wire logic [6:0] send_count,
  input wire logic send_go,
  input wire logic err_en,
  input wire logic tx_hold,
  output var ufc_pkg::ufc_rx_in_t rx_in,
  output logic tx_taken,
  output logic busy
);
  logic [6:0] left;
  logic [7:0] seq;
  // Idle data shows the inverse byte so a stale value never matches
  assign busy = left != 7'h00;
  assign rx_in = '{valid: busy, entry: '{data: busy ? seq : ~seq, pe: err_en, fe: 1'b0, bi: 1'b0}};
  // One character per ready cycle; transmit pops every other cycle unless stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 7'h00;
      seq <= 8'h00;
      tx_taken <= 1'b0;
    end else begin
      tx_taken <= tx_out.valid && !tx_hold && !tx_taken;
      if (send_go) begin
        left <= send_count;
      end else if (busy && rx_ready) begin
        left <= left - 7'h01;
        seq <= seq + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
